//--- verilog/satl_host_ctrl.sv
// host end: shifts one six-bit word on the link and pulses the load strobe
// assumes the user holds wordValid until wordReady; link clock made by divider
`timescale 1ns/1ns
module satl_host_ctrl (
    // system
    input  wire logic              clk,
    input  wire logic              rst_b,
    // user request
    input  wire logic              wordValid,
    input  wire satl_pkg::satl_step_t wordSteps,
    output logic                   wordReady,
    output logic                   busy,
    // link
    satl_link_if.host              link
);
    satl_pkg::satl_host_state_e state_q;
    satl_pkg::satl_word_t       shift_q;
    logic [satl_pkg::CNT_BITS-1:0] timer_q;
    logic [satl_pkg::CNT_BITS-1:0] bitCnt_q;
    logic                       dataOut_q;
    logic                       clkOut_q;
    logic                       strobeOut_q;

    assign wordReady = (state_q == satl_pkg::HS_IDLE);
    assign busy      = ~wordReady;
    assign link.serialData        = dataOut_q;
    assign link.serialClk         = clkOut_q;
    assign link.latch_load_strobe = strobeOut_q;

    // sequencer: low half, high half per bit, then setup gap and strobe pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q     <= satl_pkg::HS_IDLE;
            shift_q     <= '0;
            timer_q     <= '0;
            bitCnt_q    <= '0;
            dataOut_q   <= 1'b0;
            clkOut_q    <= 1'b0;
            strobeOut_q <= 1'b0;
        end else begin
            case (state_q)
                satl_pkg::HS_IDLE: begin
                    if (wordValid) begin
                        // start bit forced low, word sent msb first
                        shift_q   <= {satl_pkg::START_BIT_VALUE, wordSteps};
                        dataOut_q <= satl_pkg::START_BIT_VALUE;
                        timer_q   <= satl_pkg::HALF_CNT;
                        bitCnt_q  <= '0;
                        state_q   <= satl_pkg::HS_LOW;
                    end
                end
                satl_pkg::HS_LOW: begin
                    // data settles in the first low cycle, three cycles before the rise
                    if (timer_q == '0) begin
                        clkOut_q <= 1'b1;
                        timer_q  <= satl_pkg::HALF_CNT;
                        state_q  <= satl_pkg::HS_HIGH;
                    end else begin
                        timer_q <= timer_q - 1'b1;
                        // next bit one cycle after the fall: the old bit is held past it
                        if (timer_q == satl_pkg::HALF_CNT)
                            dataOut_q <= shift_q[satl_pkg::WORD_BITS-1];
                    end
                end
                satl_pkg::HS_HIGH: begin
                    if (timer_q == '0) begin
                        clkOut_q <= 1'b0;
                        timer_q  <= satl_pkg::HALF_CNT;
                        if (bitCnt_q == satl_pkg::BIT_LAST) begin
                            timer_q <= satl_pkg::SETUP_CNT;
                            state_q <= satl_pkg::HS_SETUP;
                        end else begin
                            // shift now; the new bit is driven one cycle after the fall
                            shift_q  <= {shift_q[satl_pkg::WORD_BITS-2:0], 1'b0};
                            bitCnt_q <= bitCnt_q + 1'b1;
                            state_q  <= satl_pkg::HS_LOW;
                        end
                    end else begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
                satl_pkg::HS_SETUP: begin
                    // strobe held low through the whole word
                    if (timer_q == '0) begin
                        strobeOut_q <= 1'b1;
                        timer_q     <= satl_pkg::WIDTH_CNT;
                        state_q     <= satl_pkg::HS_STROBE;
                    end else begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
                satl_pkg::HS_STROBE: begin
                    if (timer_q == '0) begin
                        strobeOut_q <= 1'b0;
                        state_q     <= satl_pkg::HS_IDLE;
                    end else begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
                default: begin
                    state_q     <= satl_pkg::HS_IDLE;
                    clkOut_q    <= 1'b0;
                    strobeOut_q <= 1'b0;
                end
            endcase
        end
    end
endmodule

//--- verilog/satl_pkg.sv
// constants, types and timing shared by both ends of the attenuator serial link
// assumes a 10 MHz system clock on each end; the link clock is sampled, not used as a clock
package satl_pkg;
    localparam int WORD_BITS = 6;
    localparam int STEP_BITS = 5;
    localparam int START_POS = 5;
    localparam int STEP8_POS = 4;
    localparam int STEP4_POS = 3;
    localparam int STEP2_POS = 2;
    localparam int STEP1_POS = 1;
    localparam int STEPH_POS = 0;
    localparam logic START_BIT_VALUE = 1'b0;

    localparam int CLK_PERIOD_NS = 100;
    // host link clock half period: 10 MHz / 8 = 1.25 MHz link, far under the link limit
    localparam int LINK_MAX_MHZ = 10;
    localparam int HALF_PERIOD_NS = 400;
    localparam int HALF_CYCLES = (HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_SETUP_NS = 10;
    localparam int STROBE_SETUP_CYCLES =
        ((STROBE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((STROBE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int STROBE_WIDTH_NS = 30;
    localparam int STROBE_WIDTH_CYCLES =
        ((STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int CNT_BITS = 4;
    localparam logic [CNT_BITS-1:0] HALF_CNT = CNT_BITS'(HALF_CYCLES - 1);
    localparam logic [CNT_BITS-1:0] SETUP_CNT = CNT_BITS'(STROBE_SETUP_CYCLES - 1);
    localparam logic [CNT_BITS-1:0] WIDTH_CNT = CNT_BITS'(STROBE_WIDTH_CYCLES - 1);
    localparam logic [CNT_BITS-1:0] BIT_LAST = CNT_BITS'(WORD_BITS - 1);

    typedef logic [WORD_BITS-1:0] satl_word_t;
    typedef logic [STEP_BITS-1:0] satl_step_t;

    typedef enum logic [4:0] {
        HS_IDLE   = 5'b0_0001,
        HS_LOW    = 5'b0_0010,
        HS_HIGH   = 5'b0_0100,
        HS_SETUP  = 5'b0_1000,
        HS_STROBE = 5'b1_0000
    } satl_host_state_e;
endpackage

//--- verilog/satl_link_if.sv
// serial link between host controller and attenuator word loader
// assumes all three wires are driven by the host only
`timescale 1ns/1ns
interface satl_link_if;
    logic serialData;
    logic serialClk;
    logic latch_load_strobe;

    modport host (output serialData, output serialClk, output latch_load_strobe);
    modport device (input serialData, input serialClk, input latch_load_strobe);
endinterface

//--- verilog/satl_word_loader.sv
// attenuator end: six-bit shift register, strobe-enabled hold register, power-up preset
// assumes clk is much faster than the link clock so every link edge is seen
`timescale 1ns/1ns
module satl_word_loader (
    // system
    input  wire logic              clk,
    input  wire logic              rst_b,
    // link
    satl_link_if.device            link,
    // power-up preset levels, ordered 8,4,2,1,0.5 dB from msb
    input  wire satl_pkg::satl_step_t presetSteps,
    // attenuator step controls
    output logic                   step_8db_ctrl,
    output logic                   step_4db_ctrl,
    output logic                   step_2db_ctrl,
    output logic                   step_1db_ctrl,
    output logic                   step_half_db_ctrl,
    // start bit seen high in the shift register
    output logic                   startBitErr
);
    logic [1:0]          dataSync_q;
    logic [1:0]          clkSync_q;
    logic [1:0]          strobeSync_q;
    logic                clkPrev_q;
    logic                clkRise;
    satl_pkg::satl_word_t shift_q;
    satl_pkg::satl_step_t latch_q;
    logic                presetDone_q;
    satl_pkg::satl_step_t presetMeta_q;
    satl_pkg::satl_step_t presetSync_q;

    // two-flop synchronisers on every link pin
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dataSync_q   <= 2'h0;
            clkSync_q    <= 2'h0;
            strobeSync_q <= 2'h0;
            clkPrev_q    <= 1'b0;
        end else begin
            dataSync_q   <= {dataSync_q[0], link.serialData};
            clkSync_q    <= {clkSync_q[0], link.serialClk};
            strobeSync_q <= {strobeSync_q[0], link.latch_load_strobe};
            clkPrev_q    <= clkSync_q[1];
        end
    end

    // data and clock share synchroniser depth, so data stays aligned with its edge
    assign clkRise = clkSync_q[1] & ~clkPrev_q;

    // shift on every rising link edge, strobe level ignored; oldest bit falls out
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_q <= '0;
        end else if (clkRise) begin
            shift_q <= {shift_q[satl_pkg::WORD_BITS-2:0], dataSync_q[1]};
        end
    end

    // preset pins pass two flops with no reset, so they are full when reset lifts;
    // limitation: preset levels must stand two cycles before reset release
    always_ff @(posedge clk) begin
        presetMeta_q <= presetSteps;
        presetSync_q <= presetMeta_q;
    end

    // preset is caught on the first edge after reset release, never under reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            latch_q      <= '0;
            presetDone_q <= 1'b0;
        end else if (!presetDone_q) begin
            latch_q      <= presetSync_q;
            presetDone_q <= 1'b1;
        end else if (strobeSync_q[1]) begin
            latch_q      <= shift_q[satl_pkg::STEP_BITS-1:0];
        end
    end

    // a latch is not used: a register updated each cycle while the strobe is high
    // acts transparent at link speed and keeps timing analysis simple
    assign step_8db_ctrl     = latch_q[satl_pkg::STEP8_POS];
    assign step_4db_ctrl     = latch_q[satl_pkg::STEP4_POS];
    assign step_2db_ctrl     = latch_q[satl_pkg::STEP2_POS];
    assign step_1db_ctrl     = latch_q[satl_pkg::STEP1_POS];
    assign step_half_db_ctrl = latch_q[satl_pkg::STEPH_POS];
    // flags a violated start bit; controls still follow the lower five bits
    assign startBitErr = shift_q[satl_pkg::START_POS] != satl_pkg::START_BIT_VALUE;
endmodule

//--- tb/satl_link_props.sv
// checker on the link wires between host and attenuator loader
// assumes the plain link signals and the 10 MHz system clock
`timescale 1ns/1ns
module satl_link_props (
    // system
    input wire logic clk,
    input wire logic rst_b,
    // link
    input wire logic serialData,
    input wire logic serialClk,
    input wire logic latch_load_strobe
);
    logic [3:0] bitCnt_q;
    logic       clkPrev_q;

    // previous link clock level, for edge finding
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            clkPrev_q <= 1'b0;
        else
            clkPrev_q <= serialClk;
    end

    // rising link edges since the last strobe; strobe restarts the word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            bitCnt_q <= 4'h0;
        else if (latch_load_strobe)
            bitCnt_q <= 4'h0;
        else if (serialClk && !clkPrev_q)
            bitCnt_q <= bitCnt_q + 4'h1;
    end

    a_clk_high_time: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(serialClk) |-> serialClk [*4] ##1 !serialClk) else $error("link clock high time");
    a_clk_low_time: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(serialClk) |-> !serialClk [*4]) else $error("link clock low time");
    a_data_stable_high: assert property (@(posedge clk) disable iff (!rst_b)
        serialClk |-> $stable(serialData)) else $error("data moved while clock high");
    a_data_hold_fall: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(serialClk) |-> $stable(serialData)) else $error("data moved at clock fall");
    a_strobe_after_fall: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(latch_load_strobe) |-> !serialClk && !$past(serialClk)) else $error("strobe early");
    a_strobe_width: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(latch_load_strobe) |=> !latch_load_strobe) else $error("strobe width");
    a_start_bit_zero: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(serialClk) && bitCnt_q == 4'h0 |-> !serialData) else $error("start bit high");
    a_word_six_bits: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(latch_load_strobe) |-> bitCnt_q == 4'h6) else $error("word length");
    a_strobe_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        serialClk |-> !latch_load_strobe) else $error("strobe during shift");
endmodule

//--- tb/satl_word_loader_tb_top.sv
// bench: host and loader on one link, a second loader driven by hand
// assumes 10 MHz clk; the hand-made link clock has an 800 ns period
`timescale 1ns/1ns
module satl_word_loader_tb_top;
    logic                 clk = 1'b0;
    logic                 rst_b = 1'b0;
    logic                 wordValid = 1'b0;
    satl_pkg::satl_step_t wordSteps = 5'h00;
    satl_pkg::satl_step_t presetSteps = 5'h00;
    wire [4:0]            stepsA, stepsB;
    logic                 wordReady, busy, errA, errB;
    int                   fails = 0;
    int                   testsRun = 0;
    int                   cycles = 0;
    satl_link_if          link ();
    satl_link_if          link2 ();

    satl_host_ctrl u_satl_host_ctrl (.clk(clk), .rst_b(rst_b), .wordValid(wordValid),
        .wordSteps(wordSteps), .wordReady(wordReady), .busy(busy), .link(link.host));
    satl_word_loader u_satl_word_loader (.clk(clk), .rst_b(rst_b), .link(link.device),
        .presetSteps(presetSteps), .step_8db_ctrl(stepsA[4]), .step_4db_ctrl(stepsA[3]),
        .step_2db_ctrl(stepsA[2]), .step_1db_ctrl(stepsA[1]),
        .step_half_db_ctrl(stepsA[0]), .startBitErr(errA));
    // second loader faces the bench, which may break the host rules
    satl_word_loader u_satl_word_loader2 (.clk(clk), .rst_b(rst_b), .link(link2.device),
        .presetSteps(presetSteps), .step_8db_ctrl(stepsB[4]), .step_4db_ctrl(stepsB[3]),
        .step_2db_ctrl(stepsB[2]), .step_1db_ctrl(stepsB[1]),
        .step_half_db_ctrl(stepsB[0]), .startBitErr(errB));
    satl_link_props u_satl_link_props (.clk(clk), .rst_b(rst_b), .serialData(link.serialData),
        .serialClk(link.serialClk), .latch_load_strobe(link.latch_load_strobe));

    always #50 clk = ~clk;

    // hang guard, far above the fewer than a thousand cycles the run needs
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 6000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (fails == 0 && testsRun > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // every preset level is a power-up state, reset stands in for power-up
    task automatic test_preset();
        for (int i = 0; i < 32; i++) begin
            tick(1);
            rst_b <= 1'b0;
            presetSteps <= 5'(i);
            tick(2);
            rst_b <= 1'b1;
            tick(3);
            chk("preset", 5'(i), stepsA);
        end
    endtask

    // host shifts a word; old value must hold until the strobe
    task automatic send_word(input logic [4:0] s, input logic [4:0] prev);
        tick(1);
        wordValid <= 1'b1;
        wordSteps <= s;
        tick(1);
        wordValid <= 1'b0;
        repeat (20) @(negedge clk);
        chk("busy", 5'h01, {4'h0, busy});
        chk("hold", prev, stepsA);
        repeat (80) begin
            @(negedge clk);
            if (wordReady === 1'b1)
                break;
        end
        chk("ready", 5'h01, {4'h0, wordReady});
        repeat (6) @(negedge clk);
        chk("steps", s, stepsA);
        chk("start error", 5'h00, {4'h0, errA});
    endtask

    task automatic test_words();
        logic [4:0] tbl [8] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00, 5'h1F, 5'h15};
        logic [4:0] prev;
        prev = 5'h1F;
        foreach (tbl[i]) begin
            send_word(tbl[i], prev);
            prev = tbl[i];
        end
    endtask

    // hand-made frame: n bits msb first, strobe level lvl while shifting
    task automatic bang(input logic [7:0] w, input int n, input logic lvl, input logic [4:0] held);
        tick(1);
        link2.latch_load_strobe <= lvl;
        for (int i = n - 1; i >= 0; i--) begin
            link2.serialData <= w[i];
            tick(3);
            link2.serialClk <= 1'b1;
            tick(4);
            link2.serialClk <= 1'b0;
            tick(1);
        end
        tick(4);
        chk("latch", lvl ? w[4:0] : held, stepsB);
        link2.latch_load_strobe <= 1'b1;
        tick(2);
        link2.latch_load_strobe <= 1'b0;
        link2.serialData <= ~w[0];
        tick(6);
        chk("loaded", w[4:0], stepsB);
        chk("start error", {4'h0, w[5]}, {4'h0, errB});
    endtask

    task automatic test_bad_link();
        bang(8'h0C, 6, 1'b1, 5'h1F);
        bang(8'hD6, 8, 1'b0, 5'h0C);
        bang(8'h29, 6, 1'b0, 5'h16);
    endtask

    initial begin
        link2.serialData = 1'b0;
        link2.serialClk = 1'b0;
        link2.latch_load_strobe = 1'b0;
        tick(16);
        rst_b <= 1'b1;
        test_preset();
        test_words();
        test_bad_link();
        print_verdict();
    end
endmodule
